// ==== src/jps_io_cell.sv ====
// One general-purpose pin buffer with a selectable mode.
// Assumes mode and drive data come from same-clock logic.
`timescale 1ns/100ps
`default_nettype none
module jps_io_cell (
    input  wire logic                  clk_sys_in, // System clock.
    input  wire logic                  nrst_in,    // Sync reset, active low.
    input  wire jps_pkg::jps_io_mode_t mode_in,    // Buffer mode.
    input  wire logic                  data_in,    // Value to drive.
    input  wire logic                  oe_req_in,  // Drive request.
    input  wire logic                  pin_in,     // Level read from pin.
    output var  logic                  pin_out,    // Level driven on pin.
    output var  logic                  pin_oe_out, // Pin drive enable.
    output var  logic                  rd_out      // Synchronised level.
);
    logic rd_sync;
    logic next_oe;

    jps_sync #(.RESET_VAL(jps_pkg::SYNC_RESET_VAL)) u_sync (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .async_in   (pin_in),
        .sync_out   (rd_sync)
    );

    always_comb begin
        unique case (mode_in)
            jps_pkg::JPS_IO_OUTPUT:   next_oe = 1'b1;
            jps_pkg::JPS_IO_TRISTATE: next_oe = oe_req_in;
            jps_pkg::JPS_IO_BIDIR:    next_oe = oe_req_in;
            default:                  next_oe = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            pin_out    <= 1'b0;
            pin_oe_out <= 1'b0;
        end else begin
            pin_out    <= data_in;
            pin_oe_out <= next_oe;
        end
    end

    // Input and bidirectional modes see the pin; others read zero.
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            rd_out <= 1'b0;
        end else begin
            rd_out <= (mode_in == jps_pkg::JPS_IO_INPUT ||
                       mode_in == jps_pkg::JPS_IO_BIDIR) ? rd_sync : 1'b0;
        end
    end

    a_unused_hiz: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        $past(mode_in) == jps_pkg::JPS_IO_UNUSED |-> !pin_oe_out)
        else $error("Unused pin is driven.");
    a_output_drives: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        $past(mode_in) == jps_pkg::JPS_IO_OUTPUT && $past(nrst_in)
        |-> pin_oe_out && pin_out == $past(data_in))
        else $error("Output mode pin does not drive its data.");
endmodule
`default_nettype wire

// ==== src/jps_pkg.sv ====
// Package for the test-pin sharing block: states, modes and counts.
// Assumes a 100 MHz system clock sampling an externally driven test clock.
package jps_pkg;
    // Number of consecutive mode-select-high test clock edges to logic-reset.
    localparam int unsigned RESET_TCK_COUNT = 5;
    localparam logic [2:0]  CNT_RESET_VAL   = 3'h0;
    // Number of general-purpose pins and probe node select width.
    localparam int unsigned GPIO_COUNT      = 4;
    localparam int unsigned NODE_COUNT      = 8;
    localparam int unsigned NODE_SEL_W      = 3;
    localparam logic [2:0]  NODE_SEL_RESET  = 3'h0;
    localparam logic        SYNC_RESET_VAL  = 1'b0;
    localparam logic        SYNC_RESET_HIGH = 1'b1;

    // Test access port controller states, standard sixteen-state machine.
    typedef enum logic [3:0] {
        JPS_TLR, JPS_RTI, JPS_SEL_DR, JPS_CAP_DR, JPS_SH_DR, JPS_EX1_DR,
        JPS_PA_DR, JPS_EX2_DR, JPS_UPD_DR, JPS_SEL_IR, JPS_CAP_IR,
        JPS_SH_IR, JPS_EX1_IR, JPS_PA_IR, JPS_EX2_IR, JPS_UPD_IR
    } jps_tap_state_t;

    // Buffer mode of one general-purpose pin.
    typedef enum logic [2:0] {
        JPS_IO_UNUSED, JPS_IO_INPUT, JPS_IO_OUTPUT, JPS_IO_TRISTATE,
        JPS_IO_BIDIR
    } jps_io_mode_t;
endpackage

// ==== src/jps_sync.sv ====
// Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes the input may change at any time relative to clk_sys_in.
`timescale 1ns/100ps
`default_nettype none
module jps_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk_sys_in, // System clock.
    input  wire logic nrst_in,    // Synchronous reset, active low.
    input  wire logic async_in,   // Level from outside the domain.
    output var  logic sync_out    // Synchronised level.
);
    logic stage1;

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            stage1   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// ==== src/jps_top.sv ====
// Test-pin sharing control: test access port, pin ownership and probes.
// Assumes an external scan controller drives the test pins; the test clock
// is sampled by clk_sys_in and must be much slower than it.
// Function
// - Flexible mode: mode select low claims test clock, data in, data out.
// - Claimed pins stay in scan function until logic-reset is reached.
// - At logic-reset the shared pins return to user I/O.
// - Five mode-select-high test clock edges reach logic-reset.
// - Dedicated mode: pins always scan, standard state machine only.
// - First probe drives the selected internal node in real time.
// - Second probe drives another chosen node, usable with the first.
// - After debugging, probe pins can act as user I/O.
// - Each general pin is input, output, tri-state or bidirectional.
// - Unused general pins stay high impedance.
// - Flexible mode: data out drives scan data only while mode select is low.
`timescale 1ns/100ps
`default_nettype none
module jps_top (
    input  wire logic       clk_sys_in,          // System clock, 100 MHz.
    input  wire logic       nrst_in,             // Sync reset, active low.
    input  wire logic       dedicated_mode_in,   // High: dedicated scan pins.
    input  wire logic       tck_pin_in,          // Test clock pin level.
    input  wire logic       tms_pin_in,          // Test mode select pin.
    input  wire logic       tdi_pin_in,          // Test data in pin level.
    output var  logic       tdo_pin_out,         // Test data out pin level.
    output var  logic       tdo_pin_oe_out,      // Test data out drive enable.
    output var  logic       scan_owned_out,      // Shared pins in scan use.
    output var  logic       tck_user_out,        // Test clock pin as user in.
    output var  logic       tdi_user_out,        // Data in pin as user in.
    input  wire logic       tdo_user_data_in,    // User data for data out pin.
    input  wire logic       tdo_user_oe_in,      // User drive for data out pin.
    output var  logic       tap_reset_out,       // Controller in logic-reset.
    input  wire logic [7:0] node_in,             // Internal design nodes.
    input  wire logic [2:0] probe_sel_first_in,  // Node for first probe.
    input  wire logic [2:0] probe_sel_second_in, // Node for second probe.
    input  wire logic       probe_user_first_in, // First probe is user I/O.
    input  wire logic       probe_user_second_in,// Second probe is user I/O.
    input  wire logic [1:0] probe_user_data_in,  // User data for probe pins.
    output var  logic       probe_out_first,     // First probe pin level.
    output var  logic       probe_out_second,    // Second probe pin level.
    input  wire jps_pkg::jps_io_mode_t gpio_mode_in [4], // Mode per pin.
    input  wire logic [3:0] gpio_data_in,        // Drive data per pin.
    input  wire logic [3:0] gpio_oe_req_in,      // Drive request per pin.
    input  wire logic [3:0] gpio_pin_in,         // Level read from pins.
    output var  logic [3:0] gpio_pin_out,        // Level driven on pins.
    output var  logic [3:0] gpio_pin_oe_out,     // Drive enable per pin.
    output var  logic [3:0] gpio_rd_out          // Synchronised pin levels.
);
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_prev;
    logic tck_rise;
    logic tck_fall;
    logic owned;
    logic [2:0] hi_count;
    logic shift_bit;
    jps_pkg::jps_tap_state_t tap_state;
    jps_pkg::jps_tap_state_t next_tap_state;

    // Probe node selection used twice.
    function automatic logic pick_node(input logic [7:0] nodes,
                                       input logic [2:0] sel);
        pick_node = nodes[sel];
    endfunction

    // Test clock, mode select and data in cross via two flops each. Mode
    // select resets high so an idle line does not look like a claim.
    jps_sync #(.RESET_VAL(jps_pkg::SYNC_RESET_VAL)) u_sync_tck (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .async_in   (tck_pin_in),
        .sync_out   (tck_s)
    );
    jps_sync #(.RESET_VAL(jps_pkg::SYNC_RESET_HIGH)) u_sync_tms (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .async_in   (tms_pin_in),
        .sync_out   (tms_s)
    );
    jps_sync #(.RESET_VAL(jps_pkg::SYNC_RESET_VAL)) u_sync_tdi (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .async_in   (tdi_pin_in),
        .sync_out   (tdi_s)
    );

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            tck_prev <= 1'b0;
        end else begin
            tck_prev <= tck_s;
        end
    end
    assign tck_rise = tck_s && !tck_prev;
    assign tck_fall = !tck_s && tck_prev;

    // Standard controller transitions on each sampled test clock rise.
    always_comb begin
        next_tap_state = tap_state;
        unique case (tap_state)
            jps_pkg::JPS_TLR:    next_tap_state = tms_s ? jps_pkg::JPS_TLR
                                                        : jps_pkg::JPS_RTI;
            jps_pkg::JPS_RTI:    next_tap_state = tms_s ? jps_pkg::JPS_SEL_DR
                                                        : jps_pkg::JPS_RTI;
            jps_pkg::JPS_SEL_DR: next_tap_state = tms_s ? jps_pkg::JPS_SEL_IR
                                                        : jps_pkg::JPS_CAP_DR;
            jps_pkg::JPS_CAP_DR: next_tap_state = tms_s ? jps_pkg::JPS_EX1_DR
                                                        : jps_pkg::JPS_SH_DR;
            jps_pkg::JPS_SH_DR:  next_tap_state = tms_s ? jps_pkg::JPS_EX1_DR
                                                        : jps_pkg::JPS_SH_DR;
            jps_pkg::JPS_EX1_DR: next_tap_state = tms_s ? jps_pkg::JPS_UPD_DR
                                                        : jps_pkg::JPS_PA_DR;
            jps_pkg::JPS_PA_DR:  next_tap_state = tms_s ? jps_pkg::JPS_EX2_DR
                                                        : jps_pkg::JPS_PA_DR;
            jps_pkg::JPS_EX2_DR: next_tap_state = tms_s ? jps_pkg::JPS_UPD_DR
                                                        : jps_pkg::JPS_SH_DR;
            jps_pkg::JPS_UPD_DR: next_tap_state = tms_s ? jps_pkg::JPS_SEL_DR
                                                        : jps_pkg::JPS_RTI;
            jps_pkg::JPS_SEL_IR: next_tap_state = tms_s ? jps_pkg::JPS_TLR
                                                        : jps_pkg::JPS_CAP_IR;
            jps_pkg::JPS_CAP_IR: next_tap_state = tms_s ? jps_pkg::JPS_EX1_IR
                                                        : jps_pkg::JPS_SH_IR;
            jps_pkg::JPS_SH_IR:  next_tap_state = tms_s ? jps_pkg::JPS_EX1_IR
                                                        : jps_pkg::JPS_SH_IR;
            jps_pkg::JPS_EX1_IR: next_tap_state = tms_s ? jps_pkg::JPS_UPD_IR
                                                        : jps_pkg::JPS_PA_IR;
            jps_pkg::JPS_PA_IR:  next_tap_state = tms_s ? jps_pkg::JPS_EX2_IR
                                                        : jps_pkg::JPS_PA_IR;
            jps_pkg::JPS_EX2_IR: next_tap_state = tms_s ? jps_pkg::JPS_UPD_IR
                                                        : jps_pkg::JPS_SH_IR;
            jps_pkg::JPS_UPD_IR: next_tap_state = tms_s ? jps_pkg::JPS_SEL_DR
                                                        : jps_pkg::JPS_RTI;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            tap_state <= jps_pkg::JPS_TLR;
        end else if (tck_rise) begin
            tap_state <= next_tap_state;
        end
    end

    // A second count of consecutive high samples, held at five, only feeds
    // the check below; it never forces logic-reset, the state walk does.
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            hi_count <= jps_pkg::CNT_RESET_VAL;
        end else if (tck_rise) begin
            if (!tms_s) begin
                hi_count <= jps_pkg::CNT_RESET_VAL;
            end else if (hi_count != 3'(jps_pkg::RESET_TCK_COUNT)) begin
                hi_count <= hi_count + 3'h1;
            end
        end
    end

    // Ownership: claimed by a low mode select, held until logic-reset.
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            owned <= 1'b0;
        end else if (!tms_s) begin
            owned <= 1'b1;
        end else if (tck_rise && next_tap_state == jps_pkg::JPS_TLR) begin
            owned <= 1'b0;
        end
    end

    // Data out shifts on the falling edge as the protocol expects; the
    // shift path here is a single bypass bit.
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            shift_bit <= 1'b0;
        end else if (tck_rise && (tap_state == jps_pkg::JPS_SH_DR ||
                                  tap_state == jps_pkg::JPS_SH_IR)) begin
            shift_bit <= tdi_s;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            tdo_pin_out    <= 1'b0;
            tdo_pin_oe_out <= 1'b0;
        end else if (dedicated_mode_in) begin
            tdo_pin_oe_out <= 1'b1;
            if (tck_fall) begin
                tdo_pin_out <= shift_bit;
            end
        end else if (owned || !tms_s) begin
            tdo_pin_oe_out <= !tms_s;
            if (tck_fall) begin
                tdo_pin_out <= shift_bit;
            end
        end else begin
            tdo_pin_oe_out <= tdo_user_oe_in;
            tdo_pin_out    <= tdo_user_data_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            scan_owned_out <= 1'b0;
            tck_user_out   <= 1'b0;
            tdi_user_out   <= 1'b0;
            tap_reset_out  <= 1'b1;
        end else begin
            scan_owned_out <= dedicated_mode_in || owned;
            tck_user_out   <= (dedicated_mode_in || owned) ? 1'b0 : tck_s;
            tdi_user_out   <= (dedicated_mode_in || owned) ? 1'b0 : tdi_s;
            tap_reset_out  <= tap_state == jps_pkg::JPS_TLR;
        end
    end

    // Probes: real-time nodes, or user data once debugging is done.
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            probe_out_first  <= 1'b0;
            probe_out_second <= 1'b0;
        end else begin
            probe_out_first  <= probe_user_first_in ? probe_user_data_in[0]
                : pick_node(node_in, probe_sel_first_in);
            probe_out_second <= probe_user_second_in ? probe_user_data_in[1]
                : pick_node(node_in, probe_sel_second_in);
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_io
        jps_io_cell u_cell (
            .clk_sys_in (clk_sys_in),
            .nrst_in    (nrst_in),
            .mode_in    (gpio_mode_in[g]),
            .data_in    (gpio_data_in[g]),
            .oe_req_in  (gpio_oe_req_in[g]),
            .pin_in     (gpio_pin_in[g]),
            .pin_out    (gpio_pin_out[g]),
            .pin_oe_out (gpio_pin_oe_out[g]),
            .rd_out     (gpio_rd_out[g])
        );
    end

    // The count check leans on the standard walk, which reaches
    // logic-reset within five high samples from any state.
    a_claim_on_low: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in) !tms_s |=> owned)
        else $error("Low mode select did not claim pins.");
    a_hold_until_reset: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        owned && !(tck_rise && next_tap_state == jps_pkg::JPS_TLR)
        |=> owned)
        else $error("Pins released before logic-reset.");
    a_release_at_reset: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        tms_s && tck_rise && next_tap_state == jps_pkg::JPS_TLR
        |=> !owned)
        else $error("Pins not released at logic-reset.");
    a_user_release: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        !dedicated_mode_in && !owned && tms_s
        |=> tdo_pin_oe_out == $past(tdo_user_oe_in))
        else $error("Released data out pin ignores user drive.");
    a_five_reach_reset: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        hi_count == 3'(jps_pkg::RESET_TCK_COUNT)
        |-> tap_state == jps_pkg::JPS_TLR)
        else $error("Five high edges did not reach logic-reset.");
    a_low_restarts: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        tck_rise && !tms_s |=> hi_count == jps_pkg::CNT_RESET_VAL)
        else $error("Low sample did not restart the count.");
    a_dedicated_drive: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        dedicated_mode_in |=> tdo_pin_oe_out)
        else $error("Dedicated mode data out not driven.");
    a_tdo_low_only: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in)
        !dedicated_mode_in && tms_s && owned |=> !tdo_pin_oe_out)
        else $error("Data out driven while mode select high.");
    a_probe_first: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in) !probe_user_first_in |=>
        probe_out_first == $past(node_in[probe_sel_first_in]))
        else $error("First probe does not follow its node.");
    a_probe_second: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in) !probe_user_second_in |=>
        probe_out_second == $past(node_in[probe_sel_second_in]))
        else $error("Second probe does not follow its node.");
    a_probe_user: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in) probe_user_first_in |=>
        probe_out_first == $past(probe_user_data_in[0]))
        else $error("First probe not usable as user output.");

    c_claim: cover property (@(posedge clk_sys_in)
        disable iff (!nrst_in) !owned ##1 owned);
    c_release: cover property (@(posedge clk_sys_in)
        disable iff (!nrst_in) owned ##1 !owned);
    c_shift: cover property (@(posedge clk_sys_in)
        disable iff (!nrst_in) tap_state == jps_pkg::JPS_SH_DR);
    c_dedicated: cover property (@(posedge clk_sys_in)
        disable iff (!nrst_in) dedicated_mode_in && tdo_pin_oe_out);
    c_probe_user: cover property (@(posedge clk_sys_in)
        disable iff (!nrst_in) probe_user_first_in && probe_user_second_in);
endmodule
`default_nettype wire

// ==== tb/jps_scan_model.sv ====
// Behavioural scan controller that drives the shared test pins.
// Assumes a 100 MHz clk_sys_in; one test clock period is 16 cycles.
`timescale 1ns/100ps
`default_nettype none
module jps_scan_model (
    input  wire logic clk_sys_in, // System clock used to pace the pins.
    output var  logic tck_out,    // Test clock, still low between frames.
    output var  logic tms_out,    // Mode select.
    output var  logic tdi_out     // Serial data in.
);
    initial begin
        tck_out = 1'h0;
        tms_out = 1'h1;
        tdi_out = 1'h0;
    end

    task automatic level(input logic tms, input logic tdi);
        @(posedge clk_sys_in);
        tms_out <= tms;
        tdi_out <= tdi;
    endtask

    // One 160 ns test clock period: 8 cycles low, 8 cycles high.
    task automatic pulse(input logic tms, input logic tdi);
        level(tms, tdi);
        repeat (3) @(posedge clk_sys_in);
        tck_out <= 1'h1;
        repeat (8) @(posedge clk_sys_in);
        tck_out <= 1'h0;
        repeat (4) @(posedge clk_sys_in);
        // Data in is no longer qualified, so it must not keep its value.
        tdi_out <= ~tdi;
    endtask

    // Mode select values are sent from bit 0 upwards, one per period.
    task automatic pulses(input logic [7:0] seq, input int n);
        for (int i = 0; i < n; i++) begin
            pulse(seq[i], 1'h0);
        end
    endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the test-pin sharing block.
// Assumes the scan model paces the test pins and the bench drives the rest.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    num_errors++; end end
module tb;
    logic                  clk_sys_in, nrst_in, dedicated_mode_in;
    logic                  tdo_user_data_in, tdo_user_oe_in;
    logic                  probe_user_first_in, probe_user_second_in;
    logic [7:0]            node_in;
    logic [2:0]            probe_sel_first_in, probe_sel_second_in;
    logic [1:0]            probe_user_data_in;
    logic [3:0]            gpio_data_in, gpio_oe_req_in, gpio_ext;
    jps_pkg::jps_io_mode_t gpio_mode [4];
    wire logic             tck, tms, tdi, tdo_pin_out, tdo_pin_oe_out;
    wire logic             scan_owned_out, tck_user_out, tdi_user_out;
    wire logic             tap_reset_out, probe_out_first, probe_out_second;
    wire logic [3:0]       gpio_pin_in, gpio_pin_out, gpio_pin_oe_out;
    wire logic [3:0]       gpio_rd_out;
    int                    num_errors = 0;
    int                    tests_run = 0;

    // The pin level is whatever the driving party puts on it.
    assign gpio_pin_in = (gpio_pin_oe_out & gpio_pin_out) |
                         (~gpio_pin_oe_out & gpio_ext);

    jps_scan_model ctl (.clk_sys_in(clk_sys_in), .tck_out(tck),
        .tms_out(tms), .tdi_out(tdi));

    jps_top dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .dedicated_mode_in(dedicated_mode_in), .tck_pin_in(tck),
        .tms_pin_in(tms), .tdi_pin_in(tdi), .tdo_pin_out(tdo_pin_out),
        .tdo_pin_oe_out(tdo_pin_oe_out), .scan_owned_out(scan_owned_out),
        .tck_user_out(tck_user_out), .tdi_user_out(tdi_user_out),
        .tdo_user_data_in(tdo_user_data_in),
        .tdo_user_oe_in(tdo_user_oe_in), .tap_reset_out(tap_reset_out),
        .node_in(node_in), .probe_sel_first_in(probe_sel_first_in),
        .probe_sel_second_in(probe_sel_second_in),
        .probe_user_first_in(probe_user_first_in),
        .probe_user_second_in(probe_user_second_in),
        .probe_user_data_in(probe_user_data_in),
        .probe_out_first(probe_out_first),
        .probe_out_second(probe_out_second), .gpio_mode_in(gpio_mode),
        .gpio_data_in(gpio_data_in), .gpio_oe_req_in(gpio_oe_req_in),
        .gpio_pin_in(gpio_pin_in), .gpio_pin_out(gpio_pin_out),
        .gpio_pin_oe_out(gpio_pin_oe_out), .gpio_rd_out(gpio_rd_out));

    initial begin
        clk_sys_in = 1'h0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    task automatic stop_test;
        $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Outputs are judged mid-cycle, once the edge's updates have landed.
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
    endtask

    task automatic t_reset;
        settle(1);
        `CHK(tap_reset_out, 1'h1)
        `CHK(scan_owned_out, 1'h0)
        `CHK(gpio_pin_oe_out, 4'h0)
    endtask

    task automatic t_claim;
        @(posedge clk_sys_in);
        tdo_user_data_in <= 1'h1;
        tdo_user_oe_in <= 1'h1;
        ctl.level(1'h0, 1'h0);
        settle(8);
        `CHK(scan_owned_out, 1'h1)
        `CHK(tdo_pin_oe_out, 1'h1)
        `CHK(tdi_user_out, 1'h0)
        // Walk to shift-DR, then four highs end one short of logic-reset.
        ctl.pulses(8'h02, 4);
        ctl.pulses(8'h0f, 4);
        settle(1);
        `CHK(scan_owned_out, 1'h1)
        `CHK(tdo_pin_oe_out, 1'h0)
        // Two lows reach shift-IR and the count must start over.
        ctl.pulses(8'h00, 2);
        ctl.pulses(8'h0f, 4);
        settle(1);
        `CHK(scan_owned_out, 1'h1)
        `CHK(tap_reset_out, 1'h0)
        ctl.pulse(1'h1, 1'h0);
        settle(1);
        `CHK(tap_reset_out, 1'h1)
        `CHK(scan_owned_out, 1'h0)
        `CHK(tdo_pin_oe_out, 1'h1)
        `CHK(tdo_pin_out, 1'h1)
        ctl.level(1'h1, 1'h1);
        settle(6);
        `CHK(tdi_user_out, 1'h1)
        // A released test clock pin must reach user logic mid-pulse.
        fork
            ctl.pulse(1'h1, 1'h1);
            begin
                settle(10);
                `CHK(tck_user_out, 1'h1)
            end
        join
    endtask

    task automatic t_dedicated;
        @(posedge clk_sys_in);
        dedicated_mode_in <= 1'h1;
        tdo_user_oe_in <= 1'h0;
        settle(4);
        `CHK(scan_owned_out, 1'h1)
        `CHK(tdo_pin_oe_out, 1'h1)
        @(posedge clk_sys_in);
        dedicated_mode_in <= 1'h0;
        settle(4);
        `CHK(scan_owned_out, 1'h0)
    endtask

    task automatic t_probe;
        @(posedge clk_sys_in);
        node_in <= 8'hb4;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys_in);
            probe_sel_first_in <= 3'(i);
            probe_sel_second_in <= 3'(7 - i);
            settle(2);
            `CHK(probe_out_first, node_in[i])
            `CHK(probe_out_second, node_in[7 - i])
        end
        @(posedge clk_sys_in);
        probe_user_first_in <= 1'h1;
        probe_user_second_in <= 1'h1;
        probe_user_data_in <= 2'h2;
        settle(2);
        `CHK(probe_out_first, 1'h0)
        `CHK(probe_out_second, 1'h1)
    endtask

    task automatic t_gpio;
        jps_pkg::jps_io_mode_t m;
        logic [3:0]            oe;
        logic [3:0]            rd;
        for (int k = 0; k < 5; k++) begin
            m = jps_pkg::jps_io_mode_t'(k);
            @(posedge clk_sys_in);
            for (int p = 0; p < 4; p++) gpio_mode[p] <= m;
            oe = (m == jps_pkg::JPS_IO_OUTPUT) ? 4'hf :
                 (m == jps_pkg::JPS_IO_TRISTATE ||
                  m == jps_pkg::JPS_IO_BIDIR) ? gpio_oe_req_in : 4'h0;
            rd = (m == jps_pkg::JPS_IO_INPUT || m == jps_pkg::JPS_IO_BIDIR)
                 ? ((oe & gpio_data_in) | (~oe & gpio_ext)) : 4'h0;
            settle(6);
            `CHK(gpio_pin_oe_out, oe)
            `CHK(gpio_pin_out & oe, gpio_data_in & oe)
            `CHK(gpio_rd_out, rd)
            if (k == 0) `CHK(gpio_pin_oe_out, 4'h0)
        end
    endtask

    initial begin
        nrst_in = 1'h0;
        dedicated_mode_in = 1'h0;
        tdo_user_data_in = 1'h0;
        tdo_user_oe_in = 1'h0;
        node_in = 8'h00;
        probe_sel_first_in = 3'h0;
        probe_sel_second_in = 3'h0;
        probe_user_first_in = 1'h0;
        probe_user_second_in = 1'h0;
        probe_user_data_in = 2'h0;
        gpio_data_in = 4'h5;
        gpio_oe_req_in = 4'h3;
        gpio_ext = 4'ha;
        for (int p = 0; p < 4; p++) gpio_mode[p] = jps_pkg::JPS_IO_UNUSED;
        repeat (3) @(posedge clk_sys_in);
        nrst_in <= 1'h1;
        t_reset();
        t_claim();
        t_dedicated();
        t_probe();
        t_gpio();
        stop_test();
    end

    // The sequence needs about 350 cycles, so this limit is generous.
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        num_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
